/* bench/sixteen_bit_timer_access_tb.sv */
// Testbench: host end and timer end joined over the byte bus
`timescale 1ns/10ps
`default_nettype none
module sixteen_bit_timer_access_tb;
   logic        clk = 1'h0;
   logic        srst, req, req_write, req_wide, busy, done;
   logic        ext_pin, cap_pin, cmp_out, cap_sel, wave_a, wave_b;
   logic [3:0]  req_addr;
   wire  [3:0]  irq;
   logic [15:0] req_data, resp_data, q, v;
   int          fails, samples_checked;
   always #12.5 clk = ~clk;
   stb_if u_stb_if ();
   stb_timer u_stb_timer (.clk(clk), .srst(srst), .bus(u_stb_if), .external_count_pin(ext_pin),
      .capture_pin(cap_pin), .comparator_out(cmp_out), .capture_from_comparator(cap_sel),
      .wave_out_a(wave_a), .wave_out_b(wave_b), .irq_overflow(irq[0]), .irq_match_a(irq[1]),
      .irq_match_b(irq[2]), .irq_capture(irq[3]));
   stb_host u_stb_host (.clk(clk), .srst(srst), .req(req), .req_write(req_write),
      .req_wide(req_wide), .req_addr(req_addr), .req_data(req_data), .busy(busy),
      .done(done), .resp_data(resp_data), .bus(u_stb_if));
   stb_assertions u_stb_assertions (.clk(clk), .srst(srst), .addr(u_stb_if.addr),
      .wdata(u_stb_if.wdata), .wr(u_stb_if.wr), .rd(u_stb_if.rd), .rdata(u_stb_if.rdata));
   //----------------------------------------
   // Tasks
   //----------------------------------------
   task automatic end_sim;
      $display("checks %0d fails %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Counter after a number of qualifying count-pin edges
   function automatic logic [15:0] exp_count(input logic [15:0] base, input int ticks);
      return base + 16'(ticks);
   endfunction
   // Addresses below 8 are sixteen-bit pairs
   task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
      int n;
      @(posedge clk);
      req <= 1'h1;
      req_write <= w;
      req_wide <= a < 4'h8;
      req_addr <= a;
      req_data <= d;
      @(posedge clk);
      req <= 1'h0;
      n = 0;
      while (done !== 1'h1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      if (n == 20) begin
         fails++;
         end_sim();
      end
      chk("host busy", 16'(busy), 16'h0000);
      q = (a < 4'h8) ? resp_data : {8'h00, resp_data[7:0]};
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      acc(1'h1, a, d);
   endtask
   task automatic rd(input logic [3:0] a);
      acc(1'h0, a, 16'h0000);
   endtask
   //----------------------------------------
   // Scenarios
   //----------------------------------------
   initial begin
      {srst, req, req_write, req_wide, ext_pin, cap_pin, cmp_out, cap_sel} = 8'h80;
      req_addr = 4'h0;
      req_data = 16'h0000;
      fails = 0;
      samples_checked = 0;
      v = 16'($urandom(19772));
      repeat (5) @(posedge clk);
      srst <= 1'h0;
      rd(stb_pkg::ADDR_CNT_L);
      chk("count reset", q, stb_pkg::RST_WORD);
      rd(stb_pkg::ADDR_MASK);
      chk("mask reset", q, stb_pkg::RST_WORD);
      for (int i = 0; i < 12; i++) begin
         v = (i == 0) ? stb_pkg::CNT_MAX : 16'($urandom());
         wr(4'(i % 3 * 2), v);
         rd(4'(i % 3 * 2));
         chk("wide readback", q, v);
      end
      rd(4'hd);
      chk("unmapped", q, 16'h0000);
      v = 16'($urandom() & 32'hf0);
      wr(stb_pkg::ADDR_CTRL_A, v);
      rd(stb_pkg::ADDR_CTRL_A);
      chk("control a", q, v);
      wr(stb_pkg::ADDR_CNT_L, 16'h00f0);
      wr(stb_pkg::ADDR_CTRL_B, 16'h0007);
      for (int i = 0; i < 6; i++) begin
         repeat (4) @(posedge clk);
         ext_pin <= ~ext_pin;
      end
      repeat (8) @(posedge clk);
      wr(stb_pkg::ADDR_CTRL_B, 16'h0000);
      rd(stb_pkg::ADDR_CNT_L);
      chk("external count", q, exp_count(16'h00f0, 3));
      wr(stb_pkg::ADDR_CNT_L, 16'h0100);
      wr(stb_pkg::ADDR_CMPA_L, 16'h0104);
      wr(stb_pkg::ADDR_CMPB_L, 16'h8000);
      wr(stb_pkg::ADDR_FLAG, 16'h0027);
      wr(stb_pkg::ADDR_MASK, 16'h0003);
      wr(stb_pkg::ADDR_CTRL_B, 16'h0001);
      repeat (20) @(posedge clk);
      wr(stb_pkg::ADDR_CTRL_B, 16'h0000);
      rd(stb_pkg::ADDR_FLAG);
      chk("match flag", q & 16'h0007, 16'h0002);
      chk("match irq", 16'(irq), 16'h0002);
      wr(stb_pkg::ADDR_FLAG, 16'h0002);
      rd(stb_pkg::ADDR_FLAG);
      chk("match cleared", q & 16'h0007, 16'h0000);
      wr(stb_pkg::ADDR_CNT_L, 16'hfffe);
      wr(stb_pkg::ADDR_CTRL_B, 16'h0001);
      repeat (10) @(posedge clk);
      wr(stb_pkg::ADDR_CTRL_B, 16'h0000);
      chk("overflow irq", 16'(irq), 16'h0001);
      for (int s = 0; s < 2; s++) begin
         v = 16'($urandom());
         cap_sel <= s[0];
         wr(stb_pkg::ADDR_CNT_L, v);
         wr(stb_pkg::ADDR_CTRL_B, 16'h0040);
         wr(stb_pkg::ADDR_FLAG, 16'h0027);
         if (s == 0) cap_pin <= 1'h1;
         else cmp_out <= 1'h1;
         repeat (10) @(posedge clk);
         rd(stb_pkg::ADDR_CAP_L);
         chk("capture value", q, v);
         rd(stb_pkg::ADDR_FLAG);
         chk("capture flag", q & 16'h0020, 16'h0020);
      end
      for (int u = 0; u < 2; u++) begin
         wr(stb_pkg::ADDR_CTRL_A, u ? 16'h0010 : 16'h0040);
         v = {15'h0000, u ? wave_b : wave_a};
         wr(stb_pkg::ADDR_CTRL_C, u ? 16'h0040 : 16'h0080);
         chk("forced wave", {15'h0000, u ? wave_b : wave_a}, ~v & 16'h0001);
      end
      end_sim();
   end
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      end_sim();
   end
endmodule
`default_nettype wire

/* bench/stb_assertions.sv */
// Checker: byte bus relations between host end and timer end
`timescale 1ns/10ps
`default_nettype none
module stb_assertions (
   // Clock and reset
   input wire logic       clk,
   input wire logic       srst,
   // Byte bus
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata
);
   //----------------------------------------
   // Shadow of what the bus has written
   //----------------------------------------
   logic [15:0] cnt_r, cmpa_r, cmpb_r;
   logic [7:0]  stg_r, ca_r, cb_r, msk_r;
   logic        cok_r, sok_r;
   wire         hi_w = wr && addr < 4'h8 && addr[0];
   wire         lo_w = wr && addr < 4'h8 && !addr[0];
   always_ff @(posedge clk) begin
      if (srst) begin
         {cnt_r, cmpa_r, cmpb_r} <= '0;
         {stg_r, ca_r, cb_r, msk_r} <= '0;
         cok_r <= 1'h1;
         sok_r <= 1'h1;
      end else begin
         if (hi_w) begin
            stg_r <= wdata;
            sok_r <= 1'h1;
         end
         // Counter known only while stopped
         if (rd && addr == 4'h0) begin
            stg_r <= cnt_r[15:8];
            sok_r <= cok_r;
         end
         if (rd && addr == 4'h6) sok_r <= 1'h0;
         if (lo_w && addr == 4'h0) cnt_r <= {stg_r, wdata};
         if (lo_w && addr == 4'h0) cok_r <= cb_r[2:0] == 3'h0;
         if (lo_w && addr == 4'h2) cmpa_r <= {stg_r, wdata};
         if (lo_w && addr == 4'h4) cmpb_r <= {stg_r, wdata};
         if (wr && addr == 4'h8) ca_r <= wdata;
         if (wr && addr == 4'h9) cb_r <= wdata;
         if (wr && addr == 4'h9 && wdata[2:0] != 3'h0) cok_r <= 1'h0;
         if (wr && addr == 4'hc) msk_r <= wdata;
      end
   end
   //----------------------------------------
   // Properties
   //----------------------------------------
   property p_excl;
      @(posedge clk) disable iff (srst) !(wr && rd);
   endproperty
   a_excl: assert property (p_excl) else $error("both strobes high");
   property p_hi_first;
      @(posedge clk) disable iff (srst) lo_w |-> $past(wr) && $past(addr) == (addr | 4'h1);
   endproperty
   a_hi_first: assert property (p_hi_first) else $error("low byte written first");
   property p_lo_first;
      @(posedge clk) disable iff (srst)
         rd && addr < 4'h8 && !addr[0] |=> rd && addr == ($past(addr) | 4'h1);
   endproperty
   a_lo_first: assert property (p_lo_first) else $error("high read not after low");
   property p_cmpa;
      @(posedge clk) disable iff (srst)
         rd && addr[3:1] == 3'h1 |=> rdata == ($past(addr[0]) ? cmpa_r[15:8] : cmpa_r[7:0]);
   endproperty
   a_cmpa: assert property (p_cmpa) else $error("compare a read wrong");
   property p_cmpb;
      @(posedge clk) disable iff (srst) rd && addr == 4'h5 |=> rdata == cmpb_r[15:8];
   endproperty
   a_cmpb: assert property (p_cmpb) else $error("compare b high read wrong");
   property p_cnt;
      @(posedge clk) disable iff (srst) rd && addr == 4'h0 && cok_r |=> rdata == cnt_r[7:0];
   endproperty
   a_cnt: assert property (p_cnt) else $error("stopped counter moved");
   property p_stage;
      @(posedge clk) disable iff (srst) rd && addr == 4'h1 && sok_r |=> rdata == stg_r;
   endproperty
   a_stage: assert property (p_stage) else $error("staged high byte wrong");
   property p_ctl;
      @(posedge clk) disable iff (srst) rd && addr == 4'h8 |=> rdata == ca_r;
   endproperty
   a_ctl: assert property (p_ctl) else $error("control a read wrong");
   property p_msk;
      @(posedge clk) disable iff (srst) rd && addr == 4'hc |=> rdata == msk_r;
   endproperty
   a_msk: assert property (p_msk) else $error("mask read wrong");
   property p_unmapped;
      @(posedge clk) disable iff (srst) rd && addr > 4'hc |=> rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_hold;
      @(posedge clk) disable iff (srst) !rd |=> $stable(rdata);
   endproperty
   a_hold: assert property (p_hold) else $error("read data moved without read");
endmodule
`default_nettype wire

/* src/stb_host.sv */
// Host end: issues ordered two-byte and single-byte accesses
`timescale 1ns/10ps
`default_nettype none
module stb_host (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // User request
   input  wire logic        req,
   input  wire logic        req_write,
   input  wire logic        req_wide,
   input  wire logic [3:0]  req_addr,
   input  wire logic [15:0] req_data,
   output logic             busy,
   output logic             done,
   output logic [15:0]      resp_data,
   // Bus
   stb_if.host              bus
);
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_FIRST = 3'b001,
      ST_SECOND = 3'b010,
      ST_WAIT  = 3'b011,
      ST_DONE  = 3'b100
   } stb_state_t;

   stb_state_t  state_r;
   logic        wr_r, wide_r;
   logic [3:0]  addr_r;
   logic [15:0] data_r, resp_r;
   logic [3:0]  bus_addr_r;
   logic [7:0]  bus_wdata_r;
   logic        bus_wr_r, bus_rd_r, done_r;

   // Low byte is even address; high byte is the next one
   wire [3:0] hi_addr = {addr_r[3:1], 1'b1};
   wire [3:0] lo_addr = {addr_r[3:1], 1'b0};

   always_ff @(posedge clk) begin
      if (srst) begin
         state_r <= ST_IDLE;
         wr_r <= 1'b0;
         wide_r <= 1'b0;
         addr_r <= 4'h0;
         data_r <= 16'h0000;
         resp_r <= 16'h0000;
         bus_addr_r <= 4'h0;
         bus_wdata_r <= 8'h00;
         bus_wr_r <= 1'b0;
         bus_rd_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         bus_wr_r <= 1'b0;
         bus_rd_r <= 1'b0;
         done_r <= 1'b0;
         case (state_r)
            ST_IDLE: if (req) begin
               wr_r <= req_write;
               wide_r <= req_wide;
               addr_r <= req_addr;
               data_r <= req_data;
               state_r <= ST_FIRST;
            end
            ST_FIRST: begin
               bus_wr_r <= wr_r;
               bus_rd_r <= ~wr_r;
               if (wide_r) begin
                  bus_addr_r <= wr_r ? hi_addr : lo_addr;
                  bus_wdata_r <= data_r[15:8];
                  state_r <= ST_SECOND;
               end else begin
                  bus_addr_r <= addr_r;
                  bus_wdata_r <= data_r[7:0];
                  state_r <= ST_WAIT;
               end
            end
            ST_SECOND: begin
               bus_wr_r <= wr_r;
               bus_rd_r <= ~wr_r;
               bus_addr_r <= wr_r ? lo_addr : hi_addr;
               bus_wdata_r <= data_r[7:0];
               state_r <= ST_WAIT;
            end
            ST_WAIT: begin
               if (wr_r) begin
                  done_r <= 1'b1;
                  state_r <= ST_IDLE;
               end else begin
                  // Low byte stands one cycle after its read strobe
                  if (wide_r) resp_r[7:0] <= bus.rdata;
                  state_r <= ST_DONE;
               end
            end
            ST_DONE: begin
               resp_r <= wide_r ? {bus.rdata, resp_r[7:0]} : {8'h00, bus.rdata};
               done_r <= 1'b1;
               state_r <= ST_IDLE;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   assign bus.addr  = bus_addr_r;
   assign bus.wdata = bus_wdata_r;
   assign bus.wr    = bus_wr_r;
   assign bus.rd    = bus_rd_r;
   assign busy      = state_r != ST_IDLE;
   assign done      = done_r;
   assign resp_data = resp_r;
endmodule
`default_nettype wire

/* src/stb_if.sv */
// Interface: byte bus between host end and timer end
`timescale 1ns/10ps
`default_nettype none
interface stb_if;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   modport host (output addr, output wdata, output wr, output rd, input rdata);
   modport dev  (input addr, input wdata, input wr, input rd, output rdata);
endinterface
`default_nettype wire

/* src/stb_pkg.sv */
// Package: register map, field positions, reset values and timer constants
package stb_pkg;
   //-------------------------------------------------------------
   // Register offsets
   //-------------------------------------------------------------
   localparam logic [3:0] ADDR_CNT_L   = 4'h0;
   localparam logic [3:0] ADDR_CNT_H   = 4'h1;
   localparam logic [3:0] ADDR_CMPA_L  = 4'h2;
   localparam logic [3:0] ADDR_CMPA_H  = 4'h3;
   localparam logic [3:0] ADDR_CMPB_L  = 4'h4;
   localparam logic [3:0] ADDR_CMPB_H  = 4'h5;
   localparam logic [3:0] ADDR_CAP_L   = 4'h6;
   localparam logic [3:0] ADDR_CAP_H   = 4'h7;
   localparam logic [3:0] ADDR_CTRL_A  = 4'h8;
   localparam logic [3:0] ADDR_CTRL_B  = 4'h9;
   localparam logic [3:0] ADDR_CTRL_C  = 4'ha;
   localparam logic [3:0] ADDR_FLAG    = 4'hb;
   localparam logic [3:0] ADDR_MASK    = 4'hc;
   //-------------------------------------------------------------
   // Field positions
   //-------------------------------------------------------------
   localparam int CA_WGM_LO   = 0;  // ctrl A [1:0] mode bits 1:0
   localparam int CA_COMB     = 4;  // ctrl A [5:4] wave B action
   localparam int CA_COMA     = 6;  // ctrl A [7:6] wave A action
   localparam int CB_CS       = 0;  // ctrl B [2:0] clock select
   localparam int CB_WGM2     = 3;
   localparam int CB_WGM3     = 4;  // wave_mode_bit3
   localparam int CB_EDGE     = 6;
   localparam int CB_NOISE    = 7;
   localparam int CC_FORCE_B  = 6;
   localparam int CC_FORCE_A  = 7;
   localparam int FL_OVF      = 0;
   localparam int FL_MATCH_A  = 1;
   localparam int FL_MATCH_B  = 2;
   localparam int FL_CAPTURE  = 5;
   //-------------------------------------------------------------
   // Values
   //-------------------------------------------------------------
   localparam logic [15:0] CNT_FLOOR  = 16'h0000;
   localparam logic [15:0] CNT_MAX    = 16'hffff;
   localparam logic [15:0] TOP_8BIT   = 16'h00ff;
   localparam logic [15:0] TOP_9BIT   = 16'h01ff;
   localparam logic [15:0] TOP_10BIT  = 16'h03ff;
   localparam logic [7:0]  RST_BYTE   = 8'h00;
   localparam logic [15:0] RST_WORD   = 16'h0000;
   localparam int          NOISE_LEN  = 4;
endpackage

/* src/stb_timer.sv */
// Timer end: 16-bit counter, compares, capture and byte access path
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module stb_timer #(
   parameter int PRE_W = 10
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic srst,
   // Byte bus
   stb_if.dev        bus,
   // Pins
   input  wire logic external_count_pin,
   input  wire logic capture_pin,
   input  wire logic comparator_out,
   input  wire logic capture_from_comparator,
   output logic      wave_out_a,
   output logic      wave_out_b,
   output logic      irq_overflow,
   output logic      irq_match_a,
   output logic      irq_match_b,
   output logic      irq_capture
);
   //-------------------------------------------------------------
   // State
   //-------------------------------------------------------------
   logic [7:0]       stage_r;
   logic [15:0]      count_value_r, compare_value_a_r, compare_value_b_r;
   logic [15:0]      buf_a_r, buf_b_r, capture_value_r;
   logic [7:0]       ctrl_a_r, ctrl_b_r, flag_r, mask_r, rdata_r;
   logic             up_r;
   logic [PRE_W-1:0] pre_r;
   localparam int    NOISE_LEN_W = 3;
   logic [1:0]       ext_s_r, cap_s_r;
   logic             ext_d_r, cap_d_r;
   logic [NOISE_LEN_W-1:0] nc_cnt_r;
   logic             nc_lvl_r;
   logic [7:0]       rd_mux, rd_high;
   logic             rd_copy;

   //-------------------------------------------------------------
   // Decode
   //-------------------------------------------------------------
   wire        wr_cnt_l  = bus.wr && bus.addr == stb_pkg::ADDR_CNT_L;
   wire        wr_cmpa_l = bus.wr && bus.addr == stb_pkg::ADDR_CMPA_L;
   wire        wr_cmpb_l = bus.wr && bus.addr == stb_pkg::ADDR_CMPB_L;
   wire        wr_cap_l  = bus.wr && bus.addr == stb_pkg::ADDR_CAP_L;
   wire        wr_high   = bus.wr && (bus.addr == stb_pkg::ADDR_CNT_H ||
                           bus.addr == stb_pkg::ADDR_CMPA_H ||
                           bus.addr == stb_pkg::ADDR_CMPB_H ||
                           bus.addr == stb_pkg::ADDR_CAP_H);
   wire [15:0] wr_word   = {stage_r, bus.wdata};
   wire [3:0]  wgm       = {ctrl_b_r[stb_pkg::CB_WGM3], ctrl_b_r[stb_pkg::CB_WGM2],
                            ctrl_a_r[stb_pkg::CA_WGM_LO+1], ctrl_a_r[stb_pkg::CA_WGM_LO]};
   wire [2:0]  cs        = ctrl_b_r[stb_pkg::CB_CS +: 3];

   //-------------------------------------------------------------
   // Mode decode: top, pwm style, update point
   //-------------------------------------------------------------
   logic [15:0] top;
   logic        dual, pwm, a_is_top;
   always_comb begin
      top = stb_pkg::CNT_MAX;
      dual = 1'b0;
      pwm = 1'b1;
      a_is_top = 1'b0;
      case (wgm)
         4'h0: pwm = 1'b0;
         4'h1, 4'h5: top = stb_pkg::TOP_8BIT;
         4'h2, 4'h6: top = stb_pkg::TOP_9BIT;
         4'h3, 4'h7: top = stb_pkg::TOP_10BIT;
         4'h4: begin top = compare_value_a_r; pwm = 1'b0; end
         4'hc: begin top = capture_value_r; pwm = 1'b0; end
         4'h8, 4'ha, 4'he: top = capture_value_r;
         4'h9, 4'hb, 4'hf: begin top = compare_value_a_r; a_is_top = 1'b1; end
         default: pwm = 1'b0;
      endcase
      dual = pwm && (wgm == 4'h1 || wgm == 4'h2 || wgm == 4'h3 ||
                     wgm[3:2] == 2'b10);
   end

   //-------------------------------------------------------------
   // Timer tick: prescaler or synchronised external pin
   //-------------------------------------------------------------
   wire ext_rise = ext_s_r[1] & ~ext_d_r;
   wire ext_fall = ~ext_s_r[1] & ext_d_r;
   logic timer_tick;
   always_comb begin
      case (cs)
         3'h1: timer_tick = 1'b1;
         3'h2: timer_tick = pre_r[2:0] == 3'h7;
         3'h3: timer_tick = pre_r[5:0] == 6'h3f;
         3'h4: timer_tick = pre_r[7:0] == 8'hff;
         3'h5: timer_tick = pre_r[9:0] == 10'h3ff;
         3'h6: timer_tick = ext_fall;
         3'h7: timer_tick = ext_rise;
         default: timer_tick = 1'b0;
      endcase
   end

   //-------------------------------------------------------------
   // Counter sequence
   //-------------------------------------------------------------
   wire at_floor = count_value_r == stb_pkg::CNT_FLOOR;
   wire at_max   = count_value_r == stb_pkg::CNT_MAX;
   wire at_top   = count_value_r == top;
   logic [15:0] count_nxt;
   logic        up_nxt, ovf_ev, update_pt;
   always_comb begin
      count_nxt = count_value_r;
      up_nxt = up_r;
      ovf_ev = 1'b0;
      update_pt = 1'b0;
      if (timer_tick) begin
         if (dual) begin
            if (up_r && at_top) begin
               up_nxt = 1'b0;
               count_nxt = count_value_r - 16'h0001;
               update_pt = 1'b1;
            end else if (!up_r && at_floor) begin
               up_nxt = 1'b1;
               count_nxt = count_value_r + 16'h0001;
               ovf_ev = 1'b1;
            end else begin
               count_nxt = up_r ? count_value_r + 16'h0001 : count_value_r - 16'h0001;
            end
         end else if (at_top || (!pwm && at_max)) begin
            count_nxt = stb_pkg::CNT_FLOOR;
            ovf_ev = pwm || at_max || wgm == 4'h0;
            update_pt = pwm;
         end else begin
            count_nxt = count_value_r + 16'h0001;
            up_nxt = 1'b1;
         end
      end
   end

   //-------------------------------------------------------------
   // Compare, force and capture events
   //-------------------------------------------------------------
   wire match_a = timer_tick && count_value_r == compare_value_a_r;
   wire match_b = timer_tick && count_value_r == compare_value_b_r;
   wire force_a = bus.wr && bus.addr == stb_pkg::ADDR_CTRL_C &&
                  bus.wdata[stb_pkg::CC_FORCE_A] && !pwm;
   wire force_b = bus.wr && bus.addr == stb_pkg::ADDR_CTRL_C &&
                  bus.wdata[stb_pkg::CC_FORCE_B] && !pwm;
   wire cap_src = capture_from_comparator ? comparator_out : capture_pin;
   wire cap_lvl = ctrl_b_r[stb_pkg::CB_NOISE] ? nc_lvl_r : cap_s_r[1];
   wire cap_ev  = (cap_lvl != cap_d_r) &&
                  (cap_lvl == ctrl_b_r[stb_pkg::CB_EDGE]) && wgm != 4'hc &&
                  !(wgm == 4'h8 || wgm == 4'ha || wgm == 4'he);

   function automatic logic wave_step(input logic cur, input logic [1:0] act,
                                      input logic ev, input logic pwm_m, input logic up);
      logic res;
      res = cur;
      if (ev) begin
         case (act)
            2'b01: res = ~cur;
            2'b10: res = pwm_m ? ~up : 1'b0;
            2'b11: res = pwm_m ? up : 1'b1;
            default: res = cur;
         endcase
      end
      return res;
   endfunction

   logic wave_a_r, wave_b_r;
   wire  ev_a = match_a | force_a;
   wire  ev_b = match_b | force_b;

   //-------------------------------------------------------------
   // Registers
   //-------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         stage_r <= stb_pkg::RST_BYTE;
         count_value_r <= stb_pkg::RST_WORD;
         compare_value_a_r <= stb_pkg::RST_WORD;
         compare_value_b_r <= stb_pkg::RST_WORD;
         buf_a_r <= stb_pkg::RST_WORD;
         buf_b_r <= stb_pkg::RST_WORD;
         capture_value_r <= stb_pkg::RST_WORD;
         ctrl_a_r <= stb_pkg::RST_BYTE;
         ctrl_b_r <= stb_pkg::RST_BYTE;
         flag_r <= stb_pkg::RST_BYTE;
         mask_r <= stb_pkg::RST_BYTE;
         rdata_r <= stb_pkg::RST_BYTE;
         up_r <= 1'b1;
         pre_r <= '0;
         ext_s_r <= 2'b00;
         cap_s_r <= 2'b00;
         ext_d_r <= 1'b0;
         cap_d_r <= 1'b0;
         nc_cnt_r <= '0;
         nc_lvl_r <= 1'b0;
         wave_a_r <= 1'b0;
         wave_b_r <= 1'b0;
      end else begin
         pre_r <= pre_r + 1'b1;
         ext_s_r <= {ext_s_r[0], external_count_pin};
         cap_s_r <= {cap_s_r[0], cap_src};
         ext_d_r <= ext_s_r[1];
         cap_d_r <= cap_lvl;
         if (cap_s_r[1] == nc_lvl_r) begin
            nc_cnt_r <= '0;
         end else if (nc_cnt_r == 3'(stb_pkg::NOISE_LEN - 1)) begin
            nc_lvl_r <= cap_s_r[1];
            nc_cnt_r <= '0;
         end else begin
            nc_cnt_r <= nc_cnt_r + 3'h1;
         end
         up_r <= up_nxt;
         count_value_r <= wr_cnt_l ? wr_word : count_nxt;
         if (wr_high) stage_r <= bus.wdata;
         if (wr_cmpa_l) buf_a_r <= wr_word;
         if (wr_cmpb_l) buf_b_r <= wr_word;
         if (!pwm || update_pt) begin
            compare_value_a_r <= wr_cmpa_l && !pwm ? wr_word : buf_a_r;
            compare_value_b_r <= wr_cmpb_l && !pwm ? wr_word : buf_b_r;
         end
         if (wr_cap_l) capture_value_r <= wr_word;
         else if (cap_ev) capture_value_r <= count_value_r;
         if (bus.wr && bus.addr == stb_pkg::ADDR_CTRL_A) ctrl_a_r <= bus.wdata;
         if (bus.wr && bus.addr == stb_pkg::ADDR_CTRL_B) ctrl_b_r <= bus.wdata;
         if (bus.wr && bus.addr == stb_pkg::ADDR_MASK) mask_r <= bus.wdata;
         flag_r[stb_pkg::FL_OVF] <= ovf_ev |
            (flag_r[stb_pkg::FL_OVF] & ~(bus.wr && bus.addr == stb_pkg::ADDR_FLAG &&
                                          bus.wdata[stb_pkg::FL_OVF]));
         flag_r[stb_pkg::FL_MATCH_A] <= match_a |
            (flag_r[stb_pkg::FL_MATCH_A] & ~(bus.wr && bus.addr == stb_pkg::ADDR_FLAG &&
                                              bus.wdata[stb_pkg::FL_MATCH_A]));
         flag_r[stb_pkg::FL_MATCH_B] <= match_b |
            (flag_r[stb_pkg::FL_MATCH_B] & ~(bus.wr && bus.addr == stb_pkg::ADDR_FLAG &&
                                              bus.wdata[stb_pkg::FL_MATCH_B]));
         flag_r[stb_pkg::FL_CAPTURE] <= (cap_ev & ~wr_cap_l) |
            (flag_r[stb_pkg::FL_CAPTURE] & ~(bus.wr && bus.addr == stb_pkg::ADDR_FLAG &&
                                              bus.wdata[stb_pkg::FL_CAPTURE]));
         if (!a_is_top) wave_a_r <= wave_step(wave_a_r, ctrl_a_r[stb_pkg::CA_COMA +: 2],
                                              ev_a, pwm, up_r);
         wave_b_r <= wave_step(wave_b_r, ctrl_a_r[stb_pkg::CA_COMB +: 2], ev_b, pwm, up_r);
         if (bus.rd) begin
            rdata_r <= rd_mux;
            if (rd_copy) stage_r <= rd_high;
         end
      end
   end

   //-------------------------------------------------------------
   // Read path
   //-------------------------------------------------------------
   always_comb begin
      rd_mux = 8'h00;
      rd_high = 8'h00;
      rd_copy = 1'b0;
      case (bus.addr)
         stb_pkg::ADDR_CNT_L: begin
            rd_mux = count_value_r[7:0];
            rd_high = count_value_r[15:8];
            rd_copy = 1'b1;
         end
         stb_pkg::ADDR_CAP_L: begin
            rd_mux = capture_value_r[7:0];
            rd_high = capture_value_r[15:8];
            rd_copy = 1'b1;
         end
         stb_pkg::ADDR_CNT_H, stb_pkg::ADDR_CAP_H: rd_mux = stage_r;
         stb_pkg::ADDR_CMPA_L: rd_mux = compare_value_a_r[7:0];
         stb_pkg::ADDR_CMPA_H: rd_mux = compare_value_a_r[15:8];
         stb_pkg::ADDR_CMPB_L: rd_mux = compare_value_b_r[7:0];
         stb_pkg::ADDR_CMPB_H: rd_mux = compare_value_b_r[15:8];
         stb_pkg::ADDR_CTRL_A: rd_mux = ctrl_a_r;
         stb_pkg::ADDR_CTRL_B: rd_mux = ctrl_b_r;
         stb_pkg::ADDR_FLAG: rd_mux = flag_r;
         stb_pkg::ADDR_MASK: rd_mux = mask_r;
         default: rd_mux = 8'h00;
      endcase
   end

   //-------------------------------------------------------------
   // Outputs
   //-------------------------------------------------------------
   assign bus.rdata    = rdata_r;
   assign wave_out_a   = wave_a_r;
   assign wave_out_b   = wave_b_r;
   assign irq_overflow = flag_r[stb_pkg::FL_OVF] & mask_r[stb_pkg::FL_OVF];
   assign irq_match_a  = flag_r[stb_pkg::FL_MATCH_A] & mask_r[stb_pkg::FL_MATCH_A];
   assign irq_match_b  = flag_r[stb_pkg::FL_MATCH_B] & mask_r[stb_pkg::FL_MATCH_B];
   assign irq_capture  = flag_r[stb_pkg::FL_CAPTURE] & mask_r[stb_pkg::FL_CAPTURE];
endmodule
`default_nettype wire
